// >>> hdl/tcp_timer.sv
// Purpose: 16-bit timer with clear-on-compare and fast PWM, two channels
// Assumes: synchronous active-high reset, Avalon-MM slave, one wait state
// Notes: channel 0 is channel A; the pin shows its wave only when driven
`timescale 1ns/1ps
`default_nettype none

module tcp_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [1:0] wave_out_o,
    output logic [1:0] wave_oe_o
);

    // ------------------------------------------------------------
    // byte-lane merge for 16-bit registers
    // ------------------------------------------------------------
    function automatic logic [15:0] merge16(
        input logic [15:0] old_v,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        merge16 = {be[1] ? wd[15:8] : old_v[15:8], be[0] ? wd[7:0] : old_v[7:0]};
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [tcp_pkg::CTRL_WIDTH-1:0] ctrl;
    logic [15:0] counter_value;
    logic [15:0] capture_value;
    logic [3:0] flags;
    logic [9:0] pre_cnt;
    logic blk;
    logic ack;
    logic [31:0] rdata;
    logic [15:0] cmp_act [0:1];
    logic [15:0] cmp_buf [0:1];

    // ------------------------------------------------------------
    // bus handshake: one wait state per access
    // ------------------------------------------------------------
    wire acc = avs_read_i | avs_write_i;
    wire wr_en = avs_write_i & ack;
    wire rd_go = avs_read_i & ~ack;
    assign avs_waitrequest_o = acc & ~ack;
    assign avs_readdata_o = rdata;

    // address decode
    wire sel_ctrl = avs_address_i == tcp_pkg::OFS_CTRL;
    wire sel_count = avs_address_i == tcp_pkg::OFS_COUNT;
    wire sel_cmp_a = avs_address_i == tcp_pkg::OFS_CMP_A;
    wire sel_cmp_b = avs_address_i == tcp_pkg::OFS_CMP_B;
    wire sel_capt = avs_address_i == tcp_pkg::OFS_CAPT;
    wire sel_flags = avs_address_i == tcp_pkg::OFS_FLAGS;
    wire sel_stat = avs_address_i == tcp_pkg::OFS_STAT;
    wire [1:0] sel_cmp = {sel_cmp_b, sel_cmp_a};

    wire wr_ctrl = wr_en & sel_ctrl;
    wire wr_count = wr_en & sel_count;
    wire wr_capt = wr_en & sel_capt;
    wire wr_flags = wr_en & sel_flags;

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    wire [3:0] mode = ctrl[tcp_pkg::CTRL_MODE_LSB +: 4];
    wire [2:0] clk_sel = ctrl[tcp_pkg::CTRL_CS_LSB +: 3];
    wire [1:0] pin_dir = ctrl[tcp_pkg::CTRL_DIR_LSB +: 2];

    // mode classes
    wire fixed_top = (mode == tcp_pkg::MODE_FPWM8) | (mode == tcp_pkg::MODE_FPWM9) |
        (mode == tcp_pkg::MODE_FPWM10);
    wire capt_top = (mode == tcp_pkg::MODE_CTC_CAPT) | (mode == tcp_pkg::MODE_FPWM_CAPT);
    wire cmp_top = (mode == tcp_pkg::MODE_CTC_CMP) | (mode == tcp_pkg::MODE_FPWM_CMP);
    wire is_fpwm = fixed_top | (mode == tcp_pkg::MODE_FPWM_CAPT) |
        (mode == tcp_pkg::MODE_FPWM_CMP);
    wire var_top = capt_top | cmp_top;

    // top selection, other modes run the full range
    wire [15:0] top_val =
        (mode == tcp_pkg::MODE_FPWM8) ? tcp_pkg::TOP_8 :
        (mode == tcp_pkg::MODE_FPWM9) ? tcp_pkg::TOP_9 :
        (mode == tcp_pkg::MODE_FPWM10) ? tcp_pkg::TOP_10 :
        capt_top ? capture_value :
        cmp_top ? cmp_act[0] :
        tcp_pkg::TOP_MAX;

    // mask applied to compare writes under a fixed top
    wire [15:0] cmp_mask = fixed_top ? top_val : tcp_pkg::TOP_MAX;

    // ------------------------------------------------------------
    // prescaler: one tick every N clocks
    // ------------------------------------------------------------
    wire [10:0] div_n =
        (clk_sel == tcp_pkg::CS_DIV1) ? tcp_pkg::DIV_1 :
        (clk_sel == tcp_pkg::CS_DIV8) ? tcp_pkg::DIV_8 :
        (clk_sel == tcp_pkg::CS_DIV64) ? tcp_pkg::DIV_64 :
        (clk_sel == tcp_pkg::CS_DIV256) ? tcp_pkg::DIV_256 :
        tcp_pkg::DIV_1024;
    wire [10:0] div_lim_w = div_n - 11'h001;
    wire [9:0] div_lim = div_lim_w[9:0];
    wire run = (clk_sel != tcp_pkg::CS_STOP) & (clk_sel <= tcp_pkg::CS_DIV1024);
    wire tick = run & (pre_cnt == div_lim);
    wire [9:0] next_pre = (tick | ~run) ? 10'h000 : pre_cnt + 10'h001;

    // ------------------------------------------------------------
    // counter events
    // ------------------------------------------------------------
    // a blocked tick hides the top match of a variable top as well
    wire top_eq = (counter_value == top_val) & ~(blk & var_top);
    wire top_hit = tick & top_eq;
    wire at_max = counter_value == tcp_pkg::TOP_MAX;
    wire [15:0] cnt_inc = counter_value + 16'h0001;
    // missed top runs on to the maximum and wraps
    wire [15:0] next_cnt_tick = top_eq ? tcp_pkg::BOTTOM : cnt_inc;
    wire ovf_set = tick & (is_fpwm ? top_eq : at_max);
    wire capt_set = top_hit & capt_top;
    wire bottom_ev = top_hit & is_fpwm;
    wire buf_load = top_hit & is_fpwm;
    wire [15:0] next_cnt = wr_count ? merge16(counter_value, avs_writedata_i,
        avs_byteenable_i) : tick ? next_cnt_tick : counter_value;

    // ------------------------------------------------------------
    // per-channel compare and waveform
    // ------------------------------------------------------------
    wire [1:0] cmp_eq;
    wire [1:0] wave;

    genvar g;
    generate
        for (g = 0; g < tcp_pkg::CHANNELS; g = g + 1) begin : g_ch
            logic wave_q;
            wire [1:0] act = ctrl[tcp_pkg::CTRL_ACT_LSB + 2 * g +: 2];
            wire wr_cmp = wr_en & sel_cmp[g];
            wire [15:0] wval = merge16(cmp_buf[g], avs_writedata_i,
                avs_byteenable_i) & cmp_mask;
            // toggle in PWM only for channel A with compare A as top
            wire tog_ok = is_fpwm ? ((g == 0) & (mode == tcp_pkg::MODE_FPWM_CMP)) :
                (g == 0);
            assign cmp_eq[g] = tick & ~blk & (counter_value == cmp_act[g]);

            // next waveform state, bottom wins over match in PWM
            logic next_wave;
            always_comb begin
                next_wave = wave_q;
                case (act)
                    tcp_pkg::ACT_TOGGLE: begin
                        if (cmp_eq[g] & tog_ok) begin
                            next_wave = ~wave_q;
                        end
                    end
                    tcp_pkg::ACT_NONINV: begin
                        if (is_fpwm & bottom_ev) begin
                            next_wave = 1'b1;
                        end else if (cmp_eq[g]) begin
                            next_wave = 1'b0;
                        end
                    end
                    tcp_pkg::ACT_INV: begin
                        if (is_fpwm & bottom_ev) begin
                            next_wave = 1'b0;
                        end else if (cmp_eq[g]) begin
                            next_wave = 1'b1;
                        end
                    end
                    default: begin
                        next_wave = wave_q;
                    end
                endcase
            end

            // waveform state register
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    wave_q <= 1'b0;
                end else begin
                    wave_q <= next_wave;
                end
            end

            // compare buffer and active value
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    cmp_buf[g] <= tcp_pkg::VAL_RST;
                    cmp_act[g] <= tcp_pkg::VAL_RST;
                end else begin
                    if (wr_cmp) begin
                        cmp_buf[g] <= wval;
                    end
                    if (wr_cmp & ~is_fpwm) begin
                        cmp_act[g] <= wval;
                    end else if (buf_load) begin
                        cmp_act[g] <= cmp_buf[g];
                    end
                end
            end

            assign wave[g] = wave_q;
        end
    endgenerate

    // ------------------------------------------------------------
    // flags: set wins over a write-one clear
    // ------------------------------------------------------------
    wire [3:0] flag_set = {capt_set, cmp_eq[1], cmp_eq[0], ovf_set};
    wire [3:0] flag_clr = (wr_flags & avs_byteenable_i[0]) ? avs_writedata_i[3:0] : 4'h0;
    wire [3:0] next_flags = (flags & ~flag_clr) | flag_set;

    // ------------------------------------------------------------
    // read mux, unmapped reads return zero
    // ------------------------------------------------------------
    wire [31:0] rd_mux =
        sel_ctrl ? {19'h00000, ctrl} :
        sel_count ? {16'h0000, counter_value} :
        sel_cmp_a ? {16'h0000, cmp_buf[0]} :
        sel_cmp_b ? {16'h0000, cmp_buf[1]} :
        sel_capt ? {16'h0000, capture_value} :
        sel_flags ? {28'h0000000, flags} :
        sel_stat ? {30'h00000000, wave} :
        32'h00000000;

    // bus and control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
            rdata <= 32'h00000000;
            ctrl <= tcp_pkg::CTRL_RST;
        end else begin
            ack <= acc & ~ack;
            if (rd_go) begin
                rdata <= rd_mux;
            end
            if (wr_ctrl) begin
                ctrl <= {avs_byteenable_i[1] ? avs_writedata_i[12:8] :
                    ctrl[12:8], avs_byteenable_i[0] ? avs_writedata_i[7:0] : ctrl[7:0]};
            end
        end
    end

    // counter, prescaler, block marker and capture register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            counter_value <= tcp_pkg::VAL_RST;
            pre_cnt <= 10'h000;
            blk <= 1'b0;
            capture_value <= tcp_pkg::VAL_RST;
        end else begin
            counter_value <= next_cnt;
            pre_cnt <= next_pre;
            if (wr_count) begin
                blk <= 1'b1;
            end else if (tick) begin
                blk <= 1'b0;
            end
            if (wr_capt) begin
                capture_value <= merge16(capture_value, avs_writedata_i,
                    avs_byteenable_i);
            end
        end
    end

    // flag register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags <= 4'h0;
        end else begin
            flags <= next_flags;
        end
    end

    // ------------------------------------------------------------
    // pins: wave visible only when direction is output
    // ------------------------------------------------------------
    assign wave_out_o = wave & pin_dir;
    assign wave_oe_o = pin_dir;

endmodule

`default_nettype wire

// >>> hdl/tcp_pkg.sv
// Purpose: constants for the 16-bit timer, clear-on-compare and fast PWM
// Assumes: one clock, registers on a 32-bit Avalon-MM slave
// Notes: every offset, field and code lives here, with the reset values of ctrl and the 16-bit registers
package tcp_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_COUNT = 5'h04;
    localparam logic [4:0] OFS_CMP_A = 5'h08;
    localparam logic [4:0] OFS_CMP_B = 5'h0C;
    localparam logic [4:0] OFS_CAPT = 5'h10;
    localparam logic [4:0] OFS_FLAGS = 5'h14;
    localparam logic [4:0] OFS_STAT = 5'h18;
    // ------------------------------------------------------------
    // control fields and flag bits
    // ------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_ACT_LSB = 4;
    localparam int CTRL_CS_LSB = 8;
    localparam int CTRL_DIR_LSB = 11;
    localparam int CTRL_WIDTH = 13;
    localparam int FLG_OVF = 0;
    localparam int FLG_CMP_LSB = 1;
    localparam int FLG_CAPT = 3;
    localparam int CHANNELS = 2;
    // ------------------------------------------------------------
    // waveform modes and output actions
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_CTC_CMP = 4'h4;
    localparam logic [3:0] MODE_FPWM8 = 4'h5;
    localparam logic [3:0] MODE_FPWM9 = 4'h6;
    localparam logic [3:0] MODE_FPWM10 = 4'h7;
    localparam logic [3:0] MODE_CTC_CAPT = 4'hC;
    localparam logic [3:0] MODE_FPWM_CAPT = 4'hE;
    localparam logic [3:0] MODE_FPWM_CMP = 4'hF;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_NONINV = 2'h2;
    localparam logic [1:0] ACT_INV = 2'h3;
    // ------------------------------------------------------------
    // counter limits
    // ------------------------------------------------------------
    localparam logic [15:0] TOP_8 = 16'h00FF;
    localparam logic [15:0] TOP_9 = 16'h01FF;
    localparam logic [15:0] TOP_10 = 16'h03FF;
    localparam logic [15:0] TOP_MAX = 16'hFFFF;
    localparam logic [15:0] BOTTOM = 16'h0000;
    // ------------------------------------------------------------
    // prescaler selects and division factors
    // ------------------------------------------------------------
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [10:0] DIV_1 = 11'h001;
    localparam logic [10:0] DIV_8 = 11'h008;
    localparam logic [10:0] DIV_64 = 11'h040;
    localparam logic [10:0] DIV_256 = 11'h100;
    localparam logic [10:0] DIV_1024 = 11'h400;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [CTRL_WIDTH-1:0] CTRL_RST = 13'h0000;
    localparam logic [15:0] VAL_RST = 16'h0000;
endpackage

// >>> tb/tcp_chk_asserts.sv
// Purpose: port checks on the timer bus handshake and pins
// Assumes: every access gets exactly one wait state
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module tcp_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [1:0] wave_out_o,
    input wire logic [1:0] wave_oe_o
);
    // ------------------------------------------------
    // handshake helpers and checks
    // ------------------------------------------------
    wire logic req = avs_read_i | avs_write_i;
    wire logic ack = req & ~avs_waitrequest_o;
    wire logic ctl_wr = ack & avs_write_i & (avs_address_i == tcp_pkg::OFS_CTRL);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_req_held: assert property ($rose(req) |-> avs_waitrequest_o)
        else $error("no wait state");
    chk_one_wait: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("second wait state");
    chk_ack_once: assert property (ack |=> !ack)
        else $error("double answer");
    chk_idle_free: assert property (!req |-> !avs_waitrequest_o)
        else $error("idle stall");
    chk_pin_gate: assert property ((wave_out_o & ~wave_oe_o) == 2'h0)
        else $error("pin driven while released");
    chk_dir_load: assert property (ctl_wr && avs_byteenable_i[1] |=>
        wave_oe_o == $past(avs_writedata_i[12:11])) else $error("direction not loaded");
    chk_dir_held: assert property ($changed(wave_oe_o) |-> $past(ctl_wr))
        else $error("direction moved");
    chk_hole_zero: assert property (ack && avs_read_i && avs_address_i == 5'h1C |->
        avs_readdata_o == 32'h0) else $error("unmapped read");
    chk_rdata_hold: assert property ($changed(avs_readdata_o) |->
        $past(avs_read_i && avs_waitrequest_o)) else $error("read data moved");
endmodule
bind tcp_timer tcp_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .wave_out_o(wave_out_o), .wave_oe_o(wave_oe_o));
`default_nettype wire

// >>> tb/tcp_pin_load.sv
// Purpose: load on the channel A pin, times its high and period
// Assumes: a pull-down holds the pin low while released
// Notes: all times in clock cycles
`timescale 1ns/1ps
`default_nettype none
module tcp_pin_load (
    input wire logic clk_i,
    input wire logic drive_i,
    input wire logic oe_i,
    output logic pin_o,
    output int high_o,
    output int period_o,
    output int rises_o
);
    logic prev = 1'b0;
    int since = 0;
    // released pin falls to the pull-down
    assign pin_o = oe_i ? drive_i : 1'b0;
    // times the high level and the period from the last rising edge
    always @(posedge clk_i) begin
        prev <= pin_o;
        since <= (pin_o && !prev) ? 1 : since + 1;
        if (pin_o && !prev) begin
            period_o <= since;
            rises_o <= rises_o + 1;
        end
        if (!pin_o && prev) high_o <= since;
    end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: self-checking bench for clear-on-compare and fast PWM
// Assumes: offsets 0 ctrl, 4 count, 8 compare A, 10 capture, 14 flags
// Notes: waves judged by pin period and high time in clocks
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic rd = 1'b0, wr = 1'b0, wt, pin;
    logic [4:0] adr = 5'h00;
    logic [31:0] wd = 32'h0, rdata, q = 32'h0;
    logic [1:0] wave, oe;
    int hi, per, rises;
    int fails = 0, num_checks = 0;
    // ------------------------------------------------
    // clock, design and pin load
    // ------------------------------------------------
    always #5 clk_i = ~clk_i;
    tcp_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wt), .wave_out_o(wave), .wave_oe_o(oe));
    tcp_pin_load load_u (.clk_i(clk_i), .drive_i(wave[0]), .oe_i(oe[0]), .pin_o(pin),
        .high_o(hi), .period_o(per), .rises_o(rises));
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            $display("mismatch at %0t: %s got %0h want %0h", $time, m, got, exp);
            fails++;
        end
    endtask
    // one access, held until the wait state is over
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        logic s;
        s = 1'b1;
        @(posedge clk_i);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= ~w;
        // waitrequest judged at the rising edge, request stands until then
        for (int n = 0; n < 20 && s; n++) begin
            @(posedge clk_i);
            s = wt;
        end
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        if (s) begin
            chk(32'h1, 32'h0, "bus hang");
            results();
        end
    endtask
    task automatic wait_rises(input int n);
        int r0;
        r0 = rises;
        for (int k = 0; k < 20000 && rises < r0 + n; k++) @(posedge clk_i);
        if (rises < r0 + n) begin
            chk(32'h1, 32'h0, "pin stuck");
            results();
        end
    endtask
    // control word with pin A driven
    function automatic logic [31:0] cfg(logic [3:0] m, logic [1:0] a, logic [2:0] c);
        return {19'h0, 2'h1, c, 2'h0, a, m};
    endfunction
    // stop, clear the count, start again
    task automatic restart(input logic [3:0] m, input logic [1:0] a, input logic [2:0] c);
        bus(1'b1, 5'h00, cfg(m, a, 3'h0));
        bus(1'b1, 5'h04, 32'h0);
        bus(1'b1, 5'h00, cfg(m, a, c));
    endtask
    task automatic t_ctc();
        int divs[5] = '{1, 8, 64, 256, 1024};
        bus(1'b1, 5'h1C, 32'hFFFF);
        bus(1'b0, 5'h1C, 32'h0);
        chk(q, 32'h0, "unmapped");
        bus(1'b1, 5'h08, 32'h4);
        restart(4'h4, 2'h1, 3'h1);
        wait_rises(3);
        chk(per, 32'd10, "toggle period");
        bus(1'b0, 5'h04, 32'h0);
        chk({31'h0, q <= 32'h4}, 32'h1, "count past top");
        bus(1'b0, 5'h14, 32'h0);
        chk(q & 32'hB, 32'h2, "flags");
        bus(1'b1, 5'h00, cfg(4'h4, 2'h1, 3'h0));
        bus(1'b1, 5'h08, 32'h0);
        // a written zero would block the clear at top zero, so start from the wrap
        bus(1'b1, 5'h04, 32'hFFFF);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, 5'h00, cfg(4'h4, 2'h1, 3'(i + 1)));
            wait_rises(3);
            chk(per, 32'(2 * divs[i]), "prescaled");
        end
    endtask
    task automatic t_pwm();
        logic [15:0] tops[3] = '{16'h00FF, 16'h01FF, 16'h03FF};
        logic [1:0] acts[3] = '{2'h2, 2'h3, 2'h2};
        logic [3:0] cmps[3] = '{4'h3, 4'h3, 4'h0};
        int highs[3] = '{4, 6, 1};
        for (int i = 0; i < 3; i++) begin
            restart(4'(5 + i), 2'h2, 3'h1);
            bus(1'b1, 5'h08, 32'hFFFF);
            bus(1'b0, 5'h08, 32'h0);
            chk(q, {16'h0, tops[i]}, "masked");
            bus(1'b1, 5'h08, 32'h10);
            wait_rises(3);
            chk(per, 32'(tops[i]) + 32'h1, "fixed period");
            chk(hi, 32'h11, "high time");
        end
        bus(1'b1, 5'h10, 32'h9);
        for (int i = 0; i < 3; i++) begin
            restart(4'hE, acts[i], 3'h1);
            bus(1'b1, 5'h08, {28'h0, cmps[i]});
            wait_rises(3);
            chk(per, 32'd10, "capture period");
            chk(hi, 32'(highs[i]), "duty");
        end
    endtask
    task automatic t_buf();
        // load the active top directly while in a non-PWM mode
        bus(1'b1, 5'h00, cfg(4'h4, 2'h1, 3'h0));
        bus(1'b1, 5'h08, 32'h0FFF);
        restart(4'hF, 2'h1, 3'h1);
        repeat (300) @(posedge clk_i);
        bus(1'b1, 5'h14, 32'hF);
        bus(1'b1, 5'h08, 32'h10);
        q = 32'h0;
        for (int k = 0; k < 2000 && q[0] !== 1'b1; k++) bus(1'b0, 5'h14, 32'h0);
        chk(q & 32'h3, 32'h3, "top flags");
        wait_rises(3);
        chk(per, 32'd34, "toggle period");
        chk(hi, 32'd17, "half duty");
    endtask
    task automatic t_miss();
        realtime t0;
        restart(4'h4, 2'h1, 3'h1);
        bus(1'b1, 5'h08, 32'h100);
        repeat (64) @(posedge clk_i);
        bus(1'b1, 5'h14, 32'hF);
        t0 = $realtime;
        bus(1'b1, 5'h08, 32'h10);
        q = 32'h0;
        for (int k = 0; k < 30000 && q[0] !== 1'b1; k++) bus(1'b0, 5'h14, 32'h0);
        chk(q & 32'h1, 32'h1, "wrap flag");
        chk({31'h0, ($realtime - t0) > 600000.0}, 32'h1, "match missed");
    endtask
    // count write blocks the next match, action zero keeps the wave
    task automatic t_block();
        logic [31:0] st;
        bus(1'b1, 5'h00, cfg(4'h0, 2'h0, 3'h0));
        bus(1'b1, 5'h08, 32'h8);
        bus(1'b1, 5'h04, 32'h8);
        bus(1'b1, 5'h14, 32'hF);
        bus(1'b0, 5'h18, 32'h0);
        st = q;
        bus(1'b1, 5'h00, cfg(4'h0, 2'h0, 3'h1));
        repeat (20) @(posedge clk_i);
        bus(1'b0, 5'h14, 32'h0);
        chk(q & 32'h2, 32'h0, "blocked match");
        bus(1'b1, 5'h04, 32'h2);
        repeat (20) @(posedge clk_i);
        bus(1'b0, 5'h14, 32'h0);
        chk(q & 32'h2, 32'h2, "later match");
        bus(1'b0, 5'h18, 32'h0);
        chk(q, st, "action zero");
    endtask
    // reset, then every scenario in turn
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_ctc();
        t_pwm();
        t_buf();
        t_miss();
        t_block();
        results();
    end
endmodule
`default_nettype wire
